// *** sdc_pkg.sv ***
/*
  sdc_pkg: shared constants and types for the spindle drive command
  interface: apb register map, display mode codes, input code bits,
  debounce and speed timing.
  assumes a 50 mhz pclk and a 32-bit apb bus.
*/
`default_nettype none
package sdc_pkg;
  // apb register byte addresses
  localparam logic [11:0] SDC_CTRL_OFS = 12'h000;
  localparam logic [11:0] SDC_STAT_OFS = 12'h004;
  localparam logic [11:0] SDC_DISP_OFS = 12'h008;
  localparam logic [11:0] SDC_FREQ_OFS = 12'h00c;
  localparam logic [11:0] SDC_PARM_OFS = 12'h010;
  localparam logic [11:0] SDC_CURR_OFS = 12'h014;
  // ctrl fields
  localparam int SDC_CTRL_FCLR_BIT = 0;   // software fault clear pulse
  localparam int SDC_CTRL_XFER_BIT = 1;   // parameter copy request
  localparam int SDC_CTRL_DIR_BIT = 2;    // 1 = drive to panel
  // status fields
  localparam int SDC_ST_FAULT_BIT = 0;
  localparam int SDC_ST_AGREE_BIT = 1;
  localparam int SDC_ST_ESTOP_BIT = 2;
  localparam int SDC_ST_ENCLOSS_BIT = 3;
  localparam int SDC_ST_XDIR_BIT = 4;
  localparam int SDC_ST_XDONE_BIT = 5;
  localparam int SDC_ST_ORIENT_BIT = 6;
  // reset values
  localparam logic [31:0] SDC_PARM_RST = 32'h0000_0000;
  localparam logic [15:0] SDC_FREQ_RST = 16'h0000;
  // active-input code bits
  localparam logic [15:0] SDC_CODE_FWD = 16'h0001;
  localparam logic [15:0] SDC_CODE_REV = 16'h0002;
  localparam logic [15:0] SDC_CODE_ESTOP = 16'h0004;
  localparam logic [15:0] SDC_CODE_FCLR = 16'h0008;
  localparam logic [15:0] SDC_CODE_ORIENT = 16'h0010;
  localparam logic [15:0] SDC_CODE_TAP = 16'h0020;
  // panel indicator letters (ascii)
  localparam logic [7:0] SDC_LET_F = 8'h46;
  localparam logic [7:0] SDC_LET_H = 8'h48;
  localparam logic [7:0] SDC_LET_U = 8'h55;
  localparam logic [7:0] SDC_LET_A = 8'h41;
  localparam logic [7:0] SDC_LET_R = 8'h72;
  localparam logic [7:0] SDC_LET_NONE = 8'h00;
  // full speed: 5000 rpm at 167 hz, output frequency in 0.01 hz units
  localparam logic [15:0] SDC_FMAX_CHZ = 16'h413c; // 167.00 hz
  localparam int SDC_RAMP_STEP = 1;               // 0.01 hz per tick
  // timing
  localparam int SDC_CLK_HZ = 50_000_000;
  // a 20 us window filters line noise on the pins; a switch that
  // bounces for longer needs a wider window
  localparam int SDC_DEB_US = 20;
  localparam int SDC_DEB_CYC = SDC_CLK_HZ / 1_000_000 * SDC_DEB_US;
  localparam int SDC_RAMP_US = 100;
  localparam int SDC_RAMP_CYC = SDC_CLK_HZ / 1_000_000 * SDC_RAMP_US;
  localparam int SDC_ENC_MS = 50;
  localparam int SDC_ENC_CYC = SDC_CLK_HZ / 1000 * SDC_ENC_MS;
  localparam int SDC_NIN = 7;  // fwd rev estop fclr orient tap mode

  typedef enum logic [2:0] {
    SDC_M_FIN = 3'b000,
    SDC_M_FOUT = 3'b001,
    SDC_M_INPUTS = 3'b010,
    SDC_M_CURR = 3'b011,
    SDC_M_XFER = 3'b100
  } sdc_mode_t;

  // panel display word
  typedef struct packed {
    logic [7:0] letter;
    logic [2:0] mode;
    logic [15:0] value;
  } sdc_disp_t;
endpackage : sdc_pkg
`default_nettype wire

// *** sdc_drive.sv ***
/*
  sdc_drive: command and status logic of a spindle drive with its
  panel display mode sequencer, reached over apb.
  assumes pin inputs are asynchronous, already level-shifted to logic
  levels that keep the documented polarity (0 v terminal = low).
  the analog speed reference arrives as a digitised 16-bit word.
*/
`default_nettype none
module sdc_drive
  import sdc_pkg::*;
(
  input wire logic pclk,             // 50 mhz clock
  input wire logic presetn,          // async reset, active low
  input wire logic psel,             // apb select
  input wire logic penable,          // apb access phase
  input wire logic pwrite,           // apb direction
  input wire logic [11:0] paddr,     // apb byte address
  input wire logic [31:0] pwdata,    // apb write data
  output logic [31:0] prdata,        // apb read data
  output logic pready,               // apb ready
  output logic pslverr,              // apb error on unmapped address
  input wire logic forward_run_n,    // forward run, low active
  input wire logic reverse_run_n,    // reverse run, low active
  input wire logic orient_cmd_n,     // orient request, low active
  input wire logic fault_clear_n,    // fault clear, low active
  input wire logic emergency_stop,   // e-stop, high active
  input wire logic tap_cmd_n,        // tap mode, low active
  input wire logic mode_button_n,    // panel mode button, low active
  input wire logic [15:0] speed_ref, // digitised 0..8.5 v reference
  input wire logic [15:0] motor_current, // measured current word
  input wire logic enc_a,            // spindle encoder channel a
  input wire logic enc_b,            // spindle encoder channel b
  input wire logic enc_z,            // spindle encoder index
  output logic enc_a_out,            // encoder a to controller
  output logic enc_b_out,            // encoder b to controller
  output logic enc_z_out,            // encoder index to controller
  output logic fault_out,            // high while fault present
  output logic speed_agree_n,        // low while speed matches
  output logic run_cw,               // spindle clockwise drive
  output logic run_ccw,              // spindle counter-clockwise drive
  output logic orient_active,        // orientation move in progress
  output logic [31:0] orient_angle,  // target angle to power stage
  output logic [15:0] out_freq,      // output frequency, 0.01 hz
  output sdc_disp_t disp_out         // panel display word
);

  // active-high sense of each raw input, index order fixed below
  logic [SDC_NIN-1:0] raw_act;
  assign raw_act = {~mode_button_n, ~tap_cmd_n, ~orient_cmd_n,
                    ~fault_clear_n, emergency_stop, ~reverse_run_n,
                    ~forward_run_n};

  logic [SDC_NIN-1:0] clean_q;
  logic [SDC_NIN-1:0] clean_prev_q;

  // three-stage sync then debounce counter, per input
  genvar gi;
  generate
    for (gi = 0; gi < SDC_NIN; gi++) begin : g_in
      logic s1_q, s2_q, s3_q;
      logic [19:0] cnt_q;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= raw_act[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // a change must hold for the whole window before it counts
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= 20'h00000;
          clean_q[gi] <= 1'b0;
        end else if (s2_q != s3_q || s3_q == clean_q[gi]) begin
          cnt_q <= 20'h00000;
        end else if (cnt_q == 20'(SDC_DEB_CYC - 1)) begin
          cnt_q <= 20'h00000;
          clean_q[gi] <= s3_q;
        end else begin
          cnt_q <= cnt_q + 20'h00001;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean_prev_q <= '0;
    end else begin
      clean_prev_q <= clean_q;
    end
  end

  logic forward_run_cmd, reverse_run_cmd, estop, fclr, orient, tap, btn_press;
  assign forward_run_cmd = clean_q[0];
  assign reverse_run_cmd = clean_q[1];
  assign estop = clean_q[2];
  assign fclr = clean_q[3];
  assign orient = clean_q[4];
  assign tap = clean_q[5];
  assign btn_press = clean_q[6] & ~clean_prev_q[6];

  // or of the one-hot code of each active input
  function automatic logic [15:0] input_code(input logic [5:0] a);
    logic [15:0] c;
    c = 16'h0000;
    if (a[0]) c = c | SDC_CODE_FWD;
    if (a[1]) c = c | SDC_CODE_REV;
    if (a[2]) c = c | SDC_CODE_ESTOP;
    if (a[3]) c = c | SDC_CODE_FCLR;
    if (a[4]) c = c | SDC_CODE_ORIENT;
    if (a[5]) c = c | SDC_CODE_TAP;
    return c;
  endfunction : input_code

  // display mode sequencer
  sdc_mode_t mode_q, mode_d;
  always_comb begin
    case (mode_q)
      SDC_M_FIN: mode_d = SDC_M_FOUT;
      SDC_M_FOUT: mode_d = SDC_M_INPUTS;
      SDC_M_INPUTS: mode_d = SDC_M_CURR;
      SDC_M_CURR: mode_d = SDC_M_XFER;
      SDC_M_XFER: mode_d = SDC_M_FIN;
      default: mode_d = SDC_M_FIN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= SDC_M_FIN;
    end else if (btn_press) begin
      mode_q <= mode_d;
    end
  end

  // frequency command: reference scaled so full scale gives 167 hz
  logic [15:0] freq_cmd;
  logic [31:0] freq_prod;
  // one lsb added so a full-scale word lands on 167.00 hz exactly
  assign freq_prod = (32'(speed_ref) + 32'h0000_0001) * 32'(SDC_FMAX_CHZ);
  assign freq_cmd = freq_prod[31:16];

  // fault latch and software clear, declared here because the run and
  // orient gates below already read the latch
  logic fault_q, sw_fclr;

  // run request, with e-stop overriding everything
  logic run_req, dir_ccw;
  assign run_req = ~estop & (forward_run_cmd ^ reverse_run_cmd) & ~fault_q;
  assign dir_ccw = reverse_run_cmd & ~forward_run_cmd;

  // orientation accepted only with forward present
  logic orient_ok;
  assign orient_ok = orient & forward_run_cmd & ~estop & ~fault_q;

  // ramp timer and output frequency
  logic [15:0] tick_q;
  logic tick;
  assign tick = (tick_q == 16'(SDC_RAMP_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 16'h0000;
    end else if (tick) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= tick_q + 16'h0001;
    end
  end

  logic [15:0] target;
  assign target = run_req ? freq_cmd : 16'h0000;

  // spindle decelerates on its own when run drops or e-stop is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_freq <= SDC_FREQ_RST;
    end else if (tick && out_freq < target) begin
      out_freq <= out_freq + 16'(SDC_RAMP_STEP);
    end else if (tick && out_freq > target) begin
      out_freq <= out_freq - 16'(SDC_RAMP_STEP);
    end
  end

  // direction latched while turning so a stop ramps the same way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cw <= 1'b0;
      run_ccw <= 1'b0;
    end else if (run_req) begin
      run_cw <= ~dir_ccw;
      run_ccw <= dir_ccw;
    end else if (out_freq == 16'h0000) begin
      run_cw <= 1'b0;
      run_ccw <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      orient_active <= 1'b0;
    end else begin
      orient_active <= orient_ok;
    end
  end

  // encoder loss watchdog: no enc_a edge for the window while turning
  logic ea1_q, ea2_q, ea3_q;
  logic [21:0] enc_cnt_q;
  logic enc_loss;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea1_q <= 1'b0;
      ea2_q <= 1'b0;
      ea3_q <= 1'b0;
    end else begin
      ea1_q <= enc_a;
      ea2_q <= ea1_q;
      ea3_q <= ea2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_cnt_q <= 22'h000000;
    end else if (ea2_q != ea3_q || out_freq == 16'h0000) begin
      enc_cnt_q <= 22'h000000;
    end else if (enc_cnt_q != 22'(SDC_ENC_CYC)) begin
      enc_cnt_q <= enc_cnt_q + 22'h000001;
    end
  end
  assign enc_loss = (enc_cnt_q == 22'(SDC_ENC_CYC));

  // latched fault; a new fault wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (enc_loss) begin
      fault_q <= 1'b1;
    end else if (fclr || sw_fclr) begin
      fault_q <= 1'b0;
    end
  end

  assign fault_out = fault_q;
  assign speed_agree_n = ~(out_freq == target);

  // encoder passthrough to the controller
  assign enc_a_out = enc_a;
  assign enc_b_out = enc_b;
  assign enc_z_out = enc_z;

  // parameter store and panel copy, direction chosen by software
  logic [31:0] parm_q, panel_q;
  logic xdir_q, xdone_q;
  assign orient_angle = parm_q;

  // apb slave, zero wait states
  logic wr_en, rd_en, hit;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign hit = (paddr == SDC_CTRL_OFS) || (paddr == SDC_STAT_OFS) ||
               (paddr == SDC_DISP_OFS) || (paddr == SDC_FREQ_OFS) ||
               (paddr == SDC_PARM_OFS) || (paddr == SDC_CURR_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign sw_fclr = wr_en && paddr == SDC_CTRL_OFS &&
                   pwdata[SDC_CTRL_FCLR_BIT];

  // copy only honoured in the upload/download display mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parm_q <= SDC_PARM_RST;
      panel_q <= SDC_PARM_RST;
      xdir_q <= 1'b0;
      xdone_q <= 1'b0;
    end else if (wr_en && paddr == SDC_PARM_OFS) begin
      parm_q <= pwdata;
    end else if (wr_en && paddr == SDC_CTRL_OFS &&
                 pwdata[SDC_CTRL_XFER_BIT] && mode_q == SDC_M_XFER) begin
      xdir_q <= pwdata[SDC_CTRL_DIR_BIT];
      xdone_q <= 1'b1;
      if (pwdata[SDC_CTRL_DIR_BIT]) panel_q <= parm_q;
      else parm_q <= panel_q;
    end else if (btn_press) begin
      xdone_q <= 1'b0;
    end
  end

  // display word per mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_out <= '0;
    end else begin
      disp_out.mode <= mode_q;
      case (mode_q)
        SDC_M_FIN: begin
          disp_out.letter <= SDC_LET_F;
          disp_out.value <= freq_cmd;
        end
        SDC_M_FOUT: begin
          disp_out.letter <= SDC_LET_H;
          disp_out.value <= out_freq;
        end
        SDC_M_INPUTS: begin
          disp_out.letter <= SDC_LET_U;
          disp_out.value <= input_code({tap, orient, fclr, estop, reverse_run_cmd,
                                        forward_run_cmd});
        end
        SDC_M_CURR: begin
          disp_out.letter <= SDC_LET_A;
          disp_out.value <= motor_current;
        end
        SDC_M_XFER: begin
          disp_out.letter <= SDC_LET_R; // read-zero prompt
          disp_out.value <= 16'h0000;
        end
        default: begin
          disp_out.letter <= SDC_LET_NONE;
          disp_out.value <= 16'h0000;
        end
      endcase
    end
  end

  // registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        SDC_STAT_OFS: prdata <= {25'h0, orient_active, xdone_q,
                                 xdir_q, enc_loss, estop,
                                 ~speed_agree_n, fault_q};
        SDC_DISP_OFS: prdata <= {5'h0, disp_out};
        SDC_FREQ_OFS: prdata <= {freq_cmd, out_freq};
        SDC_PARM_OFS: prdata <= parm_q;
        SDC_CURR_OFS: prdata <= {panel_q[15:0], motor_current};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : sdc_drive
`default_nettype wire

// *** sdc_drive_assertions.sv ***
/*
  sdc_drive_chk: concurrent checks on the ports of sdc_drive.
  assumes one pclk domain with presetn as its async low reset.
*/
`default_nettype none
module sdc_drive_chk
  import sdc_pkg::*;
(
  input wire logic pclk,             // clock
  input wire logic presetn,          // reset, low active
  input wire logic psel,             // apb select
  input wire logic penable,          // apb access
  input wire logic [11:0] paddr,     // apb address
  input wire logic pslverr,          // apb error
  input wire logic forward_run_n,    // forward pin
  input wire logic reverse_run_n,    // reverse pin
  input wire logic emergency_stop,   // stop pin
  input wire logic enc_a,            // encoder in
  input wire logic enc_b,            // encoder in
  input wire logic enc_z,            // encoder in
  input wire logic enc_a_out,        // encoder out
  input wire logic enc_b_out,        // encoder out
  input wire logic enc_z_out,        // encoder out
  input wire logic run_cw,           // cw drive
  input wire logic run_ccw,          // ccw drive
  input wire logic orient_active,    // orient move
  input wire logic [15:0] out_freq,  // output frequency
  input wire sdc_disp_t disp_out     // display word
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] DEB = 20'(SDC_DEB_CYC + 8);
  logic [19:0] fwd_off_q, rev_off_q, stop_on_q;

  // hold counters saturate once a level outlasts sync and debounce,
  // so a short glitch never arms the pin checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_off_q <= '0;
      rev_off_q <= '0;
      stop_on_q <= '0;
    end else begin
      fwd_off_q <= forward_run_n ? fwd_off_q + 20'(fwd_off_q != DEB) : '0;
      rev_off_q <= reverse_run_n ? rev_off_q + 20'(rev_off_q != DEB) : '0;
      stop_on_q <= emergency_stop ? stop_on_q + 20'(stop_on_q != DEB) : '0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_released;
    $rose(presetn);
  endsequence

  a_first_mode: assert property (
    s_released |=> disp_out.letter == SDC_LET_F && disp_out.mode == SDC_M_FIN)
    else $error("display did not open in frequency input mode");
  a_mode_step: assert property (
    $changed(disp_out.mode) |-> disp_out.mode ==
    (($past(disp_out.mode) == 3'd4) ? 3'd0 : $past(disp_out.mode) + 3'd1))
    else $error("display mode skipped or went backwards");
  a_mode_letter: assert property (
    disp_out.mode != SDC_M_FIN |-> disp_out.letter ==
    (disp_out.mode == SDC_M_FOUT ? SDC_LET_H :
     disp_out.mode == SDC_M_INPUTS ? SDC_LET_U :
     disp_out.mode == SDC_M_CURR ? SDC_LET_A : SDC_LET_R))
    else $error("indicator letter does not match display mode");
  a_code_bits: assert property (
    disp_out.mode == SDC_M_INPUTS |-> disp_out.value[15:6] == 10'h000)
    else $error("input code has bits beyond the six inputs");
  a_enc_pass: assert property (
    {enc_a_out, enc_b_out, enc_z_out} == {enc_a, enc_b, enc_z})
    else $error("encoder outputs differ from encoder inputs");
  a_dir_single: assert property (
    !(run_cw && run_ccw))
    else $error("both rotation directions driven");
  // direction flags stay up while a stop ramps down, so they are held
  // to zero only once the output frequency has reached zero
  a_fwd_gate: assert property (
    fwd_off_q == DEB && out_freq == 16'h0000 |=> !run_cw && !orient_active)
    else $error("clockwise run or orient without forward");
  a_rev_gate: assert property (
    rev_off_q == DEB && out_freq == 16'h0000 |=> !run_ccw)
    else $error("counter-clockwise run without reverse");
  a_stop_wins: assert property (
    stop_on_q == DEB |=> !orient_active &&
    ((!run_cw && !run_ccw) || $past(out_freq) != 16'h0000))
    else $error("motion commanded under emergency stop");
  a_stop_ramp: assert property (
    stop_on_q == DEB |=> out_freq <= $past(out_freq))
    else $error("output frequency rose under emergency stop");
  a_unmapped: assert property ( // register map
    psel && penable && paddr > SDC_CURR_OFS |-> pslverr)
    else $error("unmapped access without slave error");
endmodule : sdc_drive_chk

bind sdc_drive sdc_drive_chk i_sdc_drive_chk (.pclk, .presetn, .psel,
  .penable, .paddr, .pslverr, .forward_run_n, .reverse_run_n,
  .emergency_stop, .enc_a, .enc_b, .enc_z, .enc_a_out, .enc_b_out,
  .enc_z_out, .run_cw, .run_ccw, .orient_active, .out_freq, .disp_out);
`default_nettype wire

// *** sdc_ctl_model.sv ***
/*
  sdc_ctl_model: control computer on the pin side of the spindle drive.
  assumes cmd and spin change just after rising edges of pclk.
*/
`default_nettype none
module sdc_ctl_model (
  input wire logic pclk,             // bench clock
  input wire logic [5:0] cmd,        // fwd rev estop clr orient tap
  input wire logic spin,             // encoder turning
  output logic forward_run_n = 1'b1, // forward pin
  output logic reverse_run_n = 1'b1, // reverse pin
  output logic emergency_stop = 1'b0, // stop pin
  output logic fault_clear_n = 1'b1, // fault clear pin
  output logic orient_cmd_n = 1'b1,  // orient pin
  output logic tap_cmd_n = 1'b1,     // tap pin
  output logic enc_a,                // encoder a
  output logic enc_b,                // encoder b
  output logic enc_z                 // encoder index
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pos_q = 8'h00;

  // pins follow cmd one edge later, orient only with fwd; run inputs are low active
  always @(posedge pclk) begin
    forward_run_n <= !cmd[0];
    reverse_run_n <= !cmd[1];
    emergency_stop <= cmd[2];
    fault_clear_n <= !cmd[3];
    orient_cmd_n <= !(cmd[4] && cmd[0]);
    tap_cmd_n <= !cmd[5];
  end

  // quadrature from a step count; a parked encoder holds its lines
  always @(posedge pclk) begin
    if (spin) begin
      pos_q <= pos_q + 8'h01;
    end
  end
  assign enc_a = pos_q[1];
  assign enc_b = pos_q[1] ^ pos_q[0];
  assign enc_z = pos_q == 8'h00;
endmodule : sdc_ctl_model
`default_nettype wire

// *** tb.sv ***
/*
  tb: self-checking bench for sdc_drive; apb master tasks on one side,
  the control computer model on the pins.
  assumes sdc_drive_chk is bound to the design.
*/
`default_nettype none
module tb
  import sdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic err;
    logic [31:0] msk;
    logic [31:0] dat;
  } sdc_exp_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, spin = 1'b0, mode_button_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] cmd = 6'h00;
  logic [15:0] speed_ref = 16'h0000, motor_current = 16'h0000;
  logic [31:0] prdata, orient_angle, v;
  logic [15:0] out_freq, f;
  logic pready, pslverr, forward_run_n, reverse_run_n, emergency_stop;
  logic fault_clear_n, orient_cmd_n, tap_cmd_n, enc_a, enc_b, enc_z;
  logic enc_a_out, enc_b_out, enc_z_out, fault_out, speed_agree_n;
  logic run_cw, run_ccw, orient_active;
  sdc_disp_t disp_out;
  sdc_exp_t e;
  sdc_exp_t expq[$];
  int failures = 0;
  int n_compared = 0;
  int seed = 32'h0559;
  localparam logic [31:0] DISP_FIN = {5'h0, SDC_LET_F, 19'h0};

  always #10 pclk = ~pclk;

  sdc_ctl_model i_sdc_ctl_model (.pclk, .cmd, .spin, .forward_run_n,
    .reverse_run_n, .emergency_stop, .fault_clear_n, .orient_cmd_n,
    .tap_cmd_n, .enc_a, .enc_b, .enc_z);
  sdc_drive i_sdc_drive (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .forward_run_n, .reverse_run_n,
    .orient_cmd_n, .fault_clear_n, .emergency_stop, .tap_cmd_n,
    .mode_button_n, .speed_ref, .motor_current, .enc_a, .enc_b, .enc_z,
    .enc_a_out, .enc_b_out, .enc_z_out, .fault_out, .speed_agree_n,
    .run_cw, .run_ccw, .orient_active, .orient_angle, .out_freq,
    .disp_out);

  task automatic check(input string nm, input logic [32:0] seen,
      input logic [32:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask : check

  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // one transfer; an idle edge follows so psel is never set twice a step
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic err,
      input logic [31:0] msk, input logic [31:0] dat);
    expq.push_back('{err, msk, dat});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // press and release n times, each phase outlasting sync and debounce
  task automatic press(input int n);
    for (int k = 0; k < 2 * n; k++) begin
      mode_button_n <= k[0];
      repeat (SDC_DEB_CYC + 8) @(posedge pclk);
    end
  endtask : press

  // watcher: each completed read retires the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) begin
        failures++;
        $display("Error apb read expected none seen %h", prdata);
      end else begin
        e = expq.pop_front();
        check("apb read", {pslverr, prdata & e.msk}, {e.err, e.dat & e.msk});
      end
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("disp_out in reset", 33'(disp_out), 33'h0);
    @(posedge pclk);
    @(negedge pclk);
    check("letter", 33'(disp_out.letter), 33'(SDC_LET_F));
    check("fault_out", 33'(fault_out), 33'h0);
    check("speed_agree_n", 33'(speed_agree_n), 33'h0);
    @(posedge pclk);
    rd(SDC_DISP_OFS, 1'b0, 32'h07ff_0000, DISP_FIN);
    rd(SDC_CTRL_OFS, 1'b0, '1, 32'h0);
    rd(SDC_PARM_OFS, 1'b0, '1, SDC_PARM_RST);
    rd(12'h018, 1'b1, '1, 32'h0);
    apb(1'b1, 12'h01c, 32'hffff_ffff);
    v = $random(seed);
    apb(1'b1, SDC_PARM_OFS, v);
    rd(SDC_PARM_OFS, 1'b0, '1, v);
    check("orient_angle", 33'(orient_angle), 33'(v));
    // full scale first, then random references; nothing runs yet
    for (int i = 0; i < 3; i++) begin
      speed_ref <= (i == 0) ? 16'hffff : 16'($random(seed));
      motor_current <= 16'($random(seed));
      repeat (8) @(posedge pclk);
      f = (i == 0) ? SDC_FMAX_CHZ :
        16'(((32'(speed_ref) + 1) * 32'(SDC_FMAX_CHZ)) >> 16);
      rd(SDC_FREQ_OFS, 1'b0, '1, {f, 16'h0000});
      rd(SDC_CURR_OFS, 1'b0, '1, {16'h0000, motor_current});
    end
    // every input and the button pulsed shorter than the debounce
    spin <= 1'b1;
    cmd <= 6'h3f;
    mode_button_n <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge pclk);
      check("encoder", 33'({enc_a_out, enc_b_out, enc_z_out}),
        33'({enc_a, enc_b, enc_z}));
      check("motion", 33'({run_cw, run_ccw, orient_active}),
        33'h0);
    end
    @(posedge pclk);
    cmd <= 6'h00;
    mode_button_n <= 1'b1;
    spin <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(SDC_DISP_OFS, 1'b0, 32'h07ff_0000, DISP_FIN);
    rd(SDC_STAT_OFS, 1'b0, 32'h0000_0005, 32'h0);
    // forward with orient past the debounce; two presses reach inputs
    speed_ref <= 16'h0000;
    cmd <= 6'h11;
    press(2);
    rd(SDC_DISP_OFS, 1'b0, '1, {5'h0, SDC_LET_U, SDC_M_INPUTS,
      SDC_CODE_FWD | SDC_CODE_ORIENT});
    check("fwd orient", 33'({run_cw, run_ccw, orient_active}),
      33'h5);
    // e-stop on top of every other input but reverse
    cmd <= 6'h3d;
    repeat (SDC_DEB_CYC + 16) @(posedge pclk);
    check("stop motion", 33'({run_cw, run_ccw, orient_active}),
      33'h0);
    rd(SDC_DISP_OFS, 1'b0, '1, {5'h0, SDC_LET_U, SDC_M_INPUTS,
      SDC_CODE_FWD | SDC_CODE_ESTOP | SDC_CODE_FCLR | SDC_CODE_ORIENT |
      SDC_CODE_TAP});
    rd(SDC_STAT_OFS, 1'b0, 32'h0000_0004, 32'h0000_0004);
    cmd <= 6'h00;
    press(1);
    rd(SDC_DISP_OFS, 1'b0, '1, {5'h0, SDC_LET_A, SDC_M_CURR,
      motor_current});
    press(1);
    rd(SDC_DISP_OFS, 1'b0, '1, {5'h0, SDC_LET_R, SDC_M_XFER,
      16'h0000});
    // copy drive to panel, clear the drive word, then copy it back
    apb(1'b1, SDC_CTRL_OFS, 32'h0000_0006);
    rd(SDC_CURR_OFS, 1'b0, 32'hffff_0000, {v[15:0], 16'h0000});
    apb(1'b1, SDC_PARM_OFS, 32'h0000_0000);
    apb(1'b1, SDC_CTRL_OFS, 32'h0000_0002);
    rd(SDC_PARM_OFS, 1'b0, '1, v);
    rd(SDC_STAT_OFS, 1'b0, 32'h0000_0030, 32'h0000_0020);
    press(1);
    rd(SDC_DISP_OFS, 1'b0, 32'h07ff_0000, DISP_FIN);
    rd(SDC_STAT_OFS, 1'b0, 32'h0000_0020, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(SDC_PARM_OFS, 1'b0, '1, SDC_PARM_RST);
    rd(SDC_DISP_OFS, 1'b0, 32'h07ff_0000, DISP_FIN);
    check("pending reads", 33'(expq.size()), 33'h0);
    summarize();
  end
endmodule : tb
`default_nettype wire
